// ---- include/ocss_regs.svh ----
// register offsets, reset values, field positions of the output clock source select block
`ifndef OCSS_REGS_SVH
`define OCSS_REGS_SVH

`define OCSS_ADDR_RSVD_A 8'h22
`define OCSS_ADDR_SRC_SEL 8'h23
`define OCSS_ADDR_PWR_CTL 8'h24

`define OCSS_RST_RSVD_A 8'hF4
`define OCSS_RST_SRC_SEL 8'h8D
`define OCSS_RST_PWR_CTL 8'h9B

`define OCSS_BIT_PWR_N 7
`define OCSS_BIT_REF_FREE 6
`define OCSS_BIT_FREE_BOTH 5
`define OCSS_BIT_FIRST_STOP 3
`define OCSS_BIT_EXTRA_OE 2

`define OCSS_FLD_THIRD_PIN 7:6
`define OCSS_FLD_SECOND_PIN 5:4
`define OCSS_FLD_FIRST_PIN 3:2
`define OCSS_FLD_FIRST_DIV 1:0
`define OCSS_FLD_FOURTH_DIV 1:0

`define OCSS_SYNC_STAGES 3
`endif

// ---- include/ocss_pkg.sv ----
// types shared by the output clock source select block
package ocss_pkg;
  typedef logic [7:0] ocss_byte_type;
  typedef logic [1:0] ocss_sel_type;
  typedef logic [3:0] ocss_src_type;
endpackage

// ---- rtl/ocss_glitch_mux.sv ----
// four-input clock-level selector that changes source only while both clocks are low
`timescale 1ns/1ps
module ocss_glitch_mux
  import ocss_pkg::*;
(
  input wire logic clk_i, // block clock
  input wire logic rst_i, // async reset, active high
  input wire ocss_src_type src_i, // candidate clock levels
  input wire ocss_sel_type sel_i, // requested source
  input wire ocss_sel_type rst_sel_i, // code the selector must hold at reset release
  output ocss_sel_type cur_o, // source in use
  output logic out_o // selected clock level
);
  ocss_sel_type cur_q;
  logic out_q;
  wire safe_w = !src_i[cur_q] && !src_i[sel_i];

  // a switch at a common low level can only lengthen a low phase, never cut a high one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_q <= 2'h0;
      out_q <= 1'b0;
    end else begin
      if (sel_i != cur_q && safe_w) begin
        cur_q <= sel_i;
      end
      out_q <= src_i[cur_q];
    end
  end

  assign cur_o = cur_q;
  assign out_o = out_q;

  AST_NO_RUNT: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur_q != $past(cur_q)) |-> !out_q) else $error("source changed while output high");
  AST_SRC_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> out_q == $past(src_i[cur_q])) else $error("output does not follow source");
  // a known starting source keeps the first switch after reset on a safe boundary
  AST_START_SEL: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (cur_q == rst_sel_i)) else $error("selector did not start on reset source");
endmodule

// ---- rtl/ocss_top.sv ----
// output clock source selection, free-run and power control registers
`timescale 1ns/1ps
`include "ocss_regs.svh"
module ocss_top
  import ocss_pkg::*;
(
  input wire logic clk_i, // internal reference clock
  input wire logic rst_i, // power-on reset, async, active high
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire ocss_byte_type reg_addr_i, // register offset
  input wire ocss_byte_type reg_wdata_i, // write data
  output ocss_byte_type reg_rdata_o, // read data, registered
  input wire logic first_synth_loop_i, // first synthesizer clock level
  input wire logic reference_clock_i, // reference clock level
  input wire logic second_synth_channel_b_i, // second synth channel 2 level
  input wire logic third_synth_channel_b_i, // third synth channel 2 level
  input wire logic third_divider_seed_i, // third divider seed level
  input wire logic fifth_divider_seed_i, // fifth divider seed level
  input wire logic fourth_divider_seed_i, // fourth divider output seed level
  input wire logic third_output_divider_i, // third divider output level
  input wire logic fifth_output_divider_i, // fifth divider output level
  input wire logic first_output_divider_i, // first divider output level
  input wire logic rtc_oscillator_clock_i, // 32 kHz clock, own domain
  input wire logic clock_stop_req_i, // pin request to stop stoppable clocks
  input wire logic second_oe_i, // extra enable for pin two
  input wire logic third_oe_i, // extra enable for pin three
  output logic first_divider_src_o, // clock into the first divider
  output logic fourth_divider_src_o, // clock into the fourth divider
  output logic first_clock_pin_o, // output pin one
  output logic second_clock_pin_o, // output pin two
  output logic third_clock_pin_o, // output pin three
  output logic chip_power_down_n_o // low while chip is powered down
);
  ocss_byte_type rsvd_a_q;
  ocss_byte_type src_sel_q;
  ocss_byte_type pwr_ctl_q;
  ocss_byte_type rdata_q;

  // asynchronous pins: rtc clock, stop request, two extra enables
  logic [3:0] pin_raw_w;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_f_q;
  assign pin_raw_w = {third_oe_i, second_oe_i, clock_stop_req_i, rtc_oscillator_clock_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
          pin_f_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw_w[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_f_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  wire rtc_w = pin_f_q[0];
  wire stop_w = pin_f_q[1];
  wire oe2_w = pin_f_q[2];
  wire oe3_w = pin_f_q[3];

  // register decode
  wire wr_rsvd_w = reg_wr_i && (reg_addr_i == `OCSS_ADDR_RSVD_A);
  wire wr_src_w = reg_wr_i && (reg_addr_i == `OCSS_ADDR_SRC_SEL);
  wire wr_pwr_w = reg_wr_i && (reg_addr_i == `OCSS_ADDR_PWR_CTL);
  wire ocss_byte_type rd_mux_w =
    (reg_addr_i == `OCSS_ADDR_RSVD_A) ? rsvd_a_q :
    (reg_addr_i == `OCSS_ADDR_SRC_SEL) ? src_sel_q :
    (reg_addr_i == `OCSS_ADDR_PWR_CTL) ? pwr_ctl_q : 8'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsvd_a_q <= `OCSS_RST_RSVD_A;
      src_sel_q <= `OCSS_RST_SRC_SEL;
      pwr_ctl_q <= `OCSS_RST_PWR_CTL;
      rdata_q <= 8'h00;
    end else begin
      if (wr_rsvd_w) begin
        rsvd_a_q <= reg_wdata_i;
      end
      if (wr_src_w) begin
        src_sel_q <= reg_wdata_i;
      end
      if (wr_pwr_w) begin
        pwr_ctl_q <= reg_wdata_i;
      end
      if (reg_rd_i) begin
        rdata_q <= rd_mux_w;
      end
    end
  end

  // source vectors, indexed by the select code
  wire ocss_src_type first_output_divider_vec_w = {fourth_divider_seed_i, fourth_divider_seed_i,
                                   reference_clock_i, first_synth_loop_i};
  wire ocss_src_type fourth_output_divider_vec_w = {fifth_divider_seed_i, third_divider_seed_i,
                                   third_synth_channel_b_i, second_synth_channel_b_i};
  wire ocss_src_type pin_vec_w = {rtc_w, first_output_divider_i,
                                  fifth_output_divider_i, third_output_divider_i};

  ocss_sel_type first_output_divider_cur_w;
  ocss_sel_type fourth_output_divider_cur_w;
  logic first_output_divider_clk_w;
  logic fourth_output_divider_clk_w;
  logic [2:0] pin_clk_w;
  ocss_sel_type pin_sel_w [3];
  assign pin_sel_w[0] = src_sel_q[`OCSS_FLD_FIRST_PIN];
  assign pin_sel_w[1] = src_sel_q[`OCSS_FLD_SECOND_PIN];
  assign pin_sel_w[2] = src_sel_q[`OCSS_FLD_THIRD_PIN];

  ocss_glitch_mux u_first_output_divider_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(first_output_divider_vec_w),
    .sel_i(src_sel_q[`OCSS_FLD_FIRST_DIV]),
    .rst_sel_i(2'h0),
    .cur_o(first_output_divider_cur_w),
    .out_o(first_output_divider_clk_w)
  );

  ocss_glitch_mux u_fourth_output_divider_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(fourth_output_divider_vec_w),
    .sel_i(pwr_ctl_q[`OCSS_FLD_FOURTH_DIV]),
    .rst_sel_i(2'h0),
    .cur_o(fourth_output_divider_cur_w),
    .out_o(fourth_output_divider_clk_w)
  );

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      ocss_glitch_mux u_pin_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_i(pin_vec_w),
        .sel_i(pin_sel_w[gi]),
        .rst_sel_i(2'h0),
        .cur_o(),
        .out_o(pin_clk_w[gi])
      );
    end
  endgenerate

  // per-pin run conditions
  wire pwr_on_w = pwr_ctl_q[`OCSS_BIT_PWR_N];
  wire ref_free_w = pwr_ctl_q[`OCSS_BIT_REF_FREE];
  wire free_both_w = pwr_ctl_q[`OCSS_BIT_FREE_BOTH];
  wire extra_oe_w = pwr_ctl_q[`OCSS_BIT_EXTRA_OE];
  wire free2_w = ref_free_w;
  wire free3_w = ref_free_w && free_both_w;
  wire stop1_w = pwr_ctl_q[`OCSS_BIT_FIRST_STOP] && stop_w;
  wire run1_w = pwr_on_w && !stop1_w;
  wire run2_w = pwr_on_w && (free2_w || !stop_w) && (!extra_oe_w || oe2_w);
  wire run3_w = pwr_on_w && (free3_w || !stop_w) && (!extra_oe_w || oe3_w);
  wire [2:0] run_w = {run3_w, run2_w, run1_w};

  logic [2:0] en_q;
  logic [2:0] pin_q;
  logic first_output_divider_q;
  logic fourth_output_divider_q;
  logic pwr_n_q;
  logic first_q;

  // pin enables change only while that pin's selected clock is low, so pin gating never clips a pulse; divider feeds gate on the power bit directly
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 3'h0;
      pin_q <= 3'h0;
      first_output_divider_q <= 1'b0;
      fourth_output_divider_q <= 1'b0;
      pwr_n_q <= 1'b1;
      first_q <= 1'b1;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (!pin_clk_w[k]) begin
          en_q[k] <= run_w[k];
        end
      end
      pin_q <= pin_clk_w & en_q;
      first_output_divider_q <= first_output_divider_clk_w && pwr_on_w;
      fourth_output_divider_q <= fourth_output_divider_clk_w && pwr_on_w;
      pwr_n_q <= pwr_on_w;
      first_q <= 1'b0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign first_divider_src_o = first_output_divider_q;
  assign fourth_divider_src_o = fourth_output_divider_q;
  assign first_clock_pin_o = pin_q[0];
  assign second_clock_pin_o = pin_q[1];
  assign third_clock_pin_o = pin_q[2];
  assign chip_power_down_n_o = pwr_n_q;

  AST_RESET_VALUES: assert property (@(posedge clk_i) disable iff (rst_i)
    first_q |-> (rsvd_a_q == 8'hF4 && src_sel_q == 8'h8D && pwr_ctl_q == 8'h9B))
    else $error("register reset values wrong");
  AST_PWR_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pwr_ctl_q[7] && pin_clk_w == 3'h0) |=> ##1 (pin_q == 3'h0))
    else $error("pins run while powered down");
  AST_REF_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pwr_ctl_q[6] && stop_w && !pin_clk_w[1]) |=> !en_q[1])
    else $error("pin two not stopped");
  AST_SCOPE: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_ctl_q[7:5] == 3'b110 && stop_w && !pin_clk_w[2] && !pin_clk_w[1]
     && !pwr_ctl_q[2]) |=> (!en_q[2] && en_q[1]))
    else $error("free-run scope wrong");
  AST_FIRST_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_ctl_q[3] && stop_w && !pin_clk_w[0]) |=> !en_q[0])
    else $error("pin one not stoppable");
  AST_FOURTH_OUTPUT_DIVIDER_FIFTH: assert property (@(posedge clk_i) disable iff (rst_i)
    (fourth_output_divider_cur_w == 2'h3 && pwr_ctl_q[7]) ##1 pwr_ctl_q[7]
      |=> (fourth_output_divider_q == $past(fifth_divider_seed_i, 2)))
    else $error("fourth divider source wrong");
  AST_FIRST_OUTPUT_DIVIDER_SEED: assert property (@(posedge clk_i) disable iff (rst_i)
    (first_output_divider_cur_w[1] && pwr_ctl_q[7]) ##1 pwr_ctl_q[7]
      |=> (first_output_divider_q == $past(fourth_divider_seed_i, 2)))
    else $error("first divider source wrong");
  AST_WRITE_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_src_w |=> (src_sel_q == $past(reg_wdata_i)))
    else $error("source register write lost");
endmodule

// ---- tb/ocss_host.sv ----
// host model driving the byte-wide register port
`timescale 1ns/1ps
module ocss_host
  import ocss_pkg::*;
(
  input wire logic clk_i, // block clock
  input wire ocss_byte_type rdata_i, // read data
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output ocss_byte_type addr_o, // offset
  output ocss_byte_type wdata_o // write data
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // released lines show the inverse so a stale value cannot pass
  task automatic wr(input ocss_byte_type a, input ocss_byte_type d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input ocss_byte_type a, output ocss_byte_type d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the output clock source select block
`timescale 1ns/1ps
module tb_top
  import ocss_pkg::*;
;
  logic clk, rst, wr, rd, stop, oe2, oe3, pdn;
  ocss_byte_type addr, wdata, rdata, v;
  logic [10:0] lv;
  logic [4:0] ov;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  ocss_host u_host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata));
  ocss_top u_dut (.clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .first_synth_loop_i(lv[0]),
    .reference_clock_i(lv[1]), .fourth_divider_seed_i(lv[2]), .second_synth_channel_b_i(lv[3]),
    .third_synth_channel_b_i(lv[4]), .third_divider_seed_i(lv[5]), .fifth_divider_seed_i(lv[6]),
    .third_output_divider_i(lv[7]), .fifth_output_divider_i(lv[8]),
    .first_output_divider_i(lv[9]), .rtc_oscillator_clock_i(lv[10]), .clock_stop_req_i(stop),
    .second_oe_i(oe2), .third_oe_i(oe3), .first_divider_src_o(ov[0]),
    .fourth_divider_src_o(ov[1]), .first_clock_pin_o(ov[2]), .second_clock_pin_o(ov[3]),
    .third_clock_pin_o(ov[4]), .chip_power_down_n_o(pdn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input ocss_byte_type exp, input ocss_byte_type got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // write, let the mux settle on quiet levels, then toggle one source and count highs
  task automatic src(input ocss_byte_type a, d, input int k, idx, input logic exp_run);
    int hi;
    int bad;
    hi = 0;
    bad = 0;
    u_host.wr(a, d);
    repeat (6) @(posedge clk);
    repeat (12) begin
      @(posedge clk);
      lv[idx] <= ~lv[idx];
      repeat (3) begin
        @(negedge clk);
        if (ov[k] === 1'b1) hi++;
        else if (ov[k] !== 1'b0) bad++;
      end
    end
    @(posedge clk);
    lv <= '0;
    chk($sformatf("output %0d from source %0d", k, idx), 8'({1'b0, exp_run}),
      8'({bad > 0, hi > 0}));
  endtask
  task automatic t_reset();
    u_host.rd(8'h22, v);
    chk("reserved_control_a", 8'hF4, v);
    u_host.rd(8'h23, v);
    chk("output_source_select", 8'h8D, v);
    u_host.rd(8'h24, v);
    chk("power_freerun_divider_control", 8'h9B, v);
    u_host.rd(8'h25, v);
    chk("unmapped read", 8'h00, v);
    chk("power on", 8'h01, 8'(pdn));
  endtask
  task automatic t_rw();
    u_host.wr(8'h22, 8'h0B);
    u_host.wr(8'h30, 8'hFF);
    u_host.rd(8'h22, v);
    chk("reserved write", 8'h0B, v);
    u_host.wr(8'h22, 8'hF4);
    u_host.wr(8'h23, 8'h72);
    u_host.rd(8'h23, v);
    chk("source write", 8'h72, v);
  endtask
  task automatic t_src();
    for (int c = 0; c < 4; c++) begin
      v = {4{2'(c)}};
      src(8'h23, v, 0, (c > 1) ? 2 : c, 1'b1);
      for (int k = 2; k < 5; k++) src(8'h23, v, k, 7 + c, 1'b1);
      src(8'h24, 8'hB8 | 8'(c), 1, 3 + c, 1'b1);
    end
  endtask
  task automatic t_stop();
    ocss_byte_type tbl[5] = '{8'hB0, 8'hB8, 8'hD8, 8'hF8, 8'hFC};
    logic [2:0] run[5] = '{3'b001, 3'b000, 3'b010, 3'b110, 3'b100};
    u_host.wr(8'h23, 8'h00);
    stop <= 1'b1;
    oe3 <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      for (int p = 0; p < 3; p++) src(8'h24, tbl[i], 2 + p, 7, run[i][p]);
    end
    stop <= 1'b0;
  endtask
  task automatic t_pwr();
    src(8'h24, 8'h3B, 0, 0, 1'b0);
    chk("power down", 8'h00, 8'(pdn));
    src(8'h24, 8'h3B, 1, 6, 1'b0);
    src(8'h24, 8'h3B, 3, 7, 1'b0);
    u_host.wr(8'h24, 8'h9B);
    repeat (3) @(posedge clk);
    chk("power restored", 8'h01, 8'(pdn));
  endtask
  initial begin
    rst = 1'b1;
    lv = '0;
    stop = 1'b0;
    oe2 = 1'b0;
    oe3 = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_src();
    t_stop();
    t_pwr();
    print_verdict();
  end
endmodule
